//--- rtl/asp_serial_port.sv
// serial host port with dual data-out, return strobe and register map
module asp_serial_port (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic sclk_i,
    input wire logic convert_select_input_i,
    input wire logic sdi_i,
    input wire logic [31:0] sample_word_i,
    input wire logic conv_done_i,
    input wire logic alarm_level_i,
    output logic primary_data_out_o,
    output logic shared_alarm_output_pin_o,
    output logic return_strobe_pin_o,
    output logic nap_mode_o,
    output logic power_down_o,
    output logic supply_alarm_disable_o,
    output logic input_alarm_disable_o
);
    // =========================================================
    // pin synchronisers
    asp_pkg::asp_link_t s1_reg, s2_reg, prev_reg, pins;
    assign pins = '{reset_n: reset_pin_n_i, sclk: sclk_i,
        frame_n: convert_select_input_i, sdi: sdi_i};
    // two flops, then a third copy for edge detection
    always_ff @(posedge core_clk_i) begin
        s1_reg <= pins;
        s2_reg <= s1_reg;
        prev_reg <= s2_reg;
    end

    // =========================================================
    // state
    logic [31:0] file_reg [asp_pkg::NREG];
    logic [31:0] file_next [asp_pkg::NREG];
    logic [31:0] in_sr_reg, in_sr_next, out_sr_reg, out_sr_next;
    logic [31:0] rd_word_reg, rd_word_next, rd_word;
    logic [5:0] in_cnt_reg, in_cnt_next, left_reg, left_next;
    logic [3:0] div_reg, div_next;
    logic rd_pend_reg, rd_pend_next, skip_reg, skip_next;
    logic strobe_reg, strobe_next, shared_reg, shared_next;
    logic nap_reg, nap_next;
    logic rise, fall, in_frame, f_start, f_end, cpol, cpha;
    logic capture, launch, source_synchronous_mode, int_sel, dual, tick;
    logic shift_en;
    logic pin_rst, por_rst, app_rst, wr_en;
    logic [1:0] cfg;
    logic [7:0] wr_addr, wr_data;

    // edge and mode decode
    assign rise = s2_reg.sclk & ~prev_reg.sclk;
    assign fall = ~s2_reg.sclk & prev_reg.sclk;
    assign in_frame = ~s2_reg.frame_n;
    assign f_start = prev_reg.frame_n & ~s2_reg.frame_n;
    assign f_end = ~prev_reg.frame_n & s2_reg.frame_n;
    assign cpol = file_reg[asp_pkg::IDX_IN][asp_pkg::CPOL_BIT];
    assign cpha = file_reg[asp_pkg::IDX_IN][asp_pkg::CPHA_BIT];
    assign capture = (cpol == cpha) ? rise : fall;
    assign launch = (cpol == cpha) ? fall : rise;
    assign cfg = file_reg[asp_pkg::IDX_OUT][asp_pkg::CFG_LSB +: 2];
    assign dual = (cfg == asp_pkg::CFG_DUAL);
    assign source_synchronous_mode =
        file_reg[asp_pkg::IDX_OUT][asp_pkg::MODE_LSB +: 2] !=
        asp_pkg::MODE_SPI;
    // select bit zero keeps the host clock as the source
    assign int_sel = source_synchronous_mode &
        file_reg[asp_pkg::IDX_OUT][asp_pkg::RETURN_SEL_BIT];
    assign tick = (div_reg == 4'(asp_pkg::INT_HALF_CYC - 1));
    // one launch per edge in either width keeps timing equal
    assign shift_en = int_sel ?
        (in_frame & tick & strobe_reg & (left_reg != 6'h00)) :
        (in_frame & launch & ~skip_reg);

    // reset classes: pin acts as app reset only when class bit set
    assign pin_rst = ~s2_reg.reset_n;
    assign por_rst = rst_i |
        (pin_rst & ~file_reg[asp_pkg::IDX_PWR][asp_pkg::CLASS_BIT]);
    assign app_rst = pin_rst &
        file_reg[asp_pkg::IDX_PWR][asp_pkg::CLASS_BIT];

    // completed write frame: opcode, byte address, data byte
    assign wr_en = f_end & (in_cnt_reg >= 6'(asp_pkg::FRAME_BITS)) &
        (in_sr_reg[asp_pkg::OP_MSB -: 8] == asp_pkg::OP_WRITE);
    assign wr_addr = in_sr_reg[asp_pkg::ADDR_LSB +: 8];
    assign wr_data = in_sr_reg[7:0];

    // =========================================================
    // register file next state and read mux
    always_comb begin
        logic [7:0] m;
        logic [1:0] lane;
        m = 8'h00;
        lane = wr_addr[1:0]; // byte lane within the word
        rd_word = 32'h0000_0000;
        for (int i = 0; i < asp_pkg::NREG; i++) begin
            file_next[i] = file_reg[i];
            // base address decode
            if (wr_en && wr_addr[7:2] == asp_pkg::REG_ADDR[i][7:2]) begin
                m = asp_pkg::REG_MASK[i][{lane, 3'b000} +: 8];
                // low control bits locked until the key is set
                if (i == asp_pkg::IDX_PWR && lane == 2'b00 &&
                    file_reg[i][asp_pkg::KEY_LSB +: 8] !=
                    asp_pkg::UNLOCK_KEY) begin
                    m = 8'h00;
                end
                // reserved bits never take a write
                file_next[i][{lane, 3'b000} +: 8] = (wr_data & m) |
                    (file_reg[i][{lane, 3'b000} +: 8] & ~m);
            end
            if (por_rst) begin
                file_next[i] = 32'h0000_0000;
            end else if (app_rst) begin
                // class and nap survive an application reset
                file_next[i] = (i == asp_pkg::IDX_PWR) ?
                    (file_reg[i] & asp_pkg::POR_ONLY_MASK) : 32'h0000_0000;
            end
            if (in_sr_reg[asp_pkg::ADDR_LSB + 2 +: 6] ==
                asp_pkg::REG_ADDR[i][7:2]) begin
                rd_word = file_reg[i];
            end
        end
    end

    // =========================================================
    // shifter, strobe and power next state
    always_comb begin
        in_sr_next = in_sr_reg;
        in_cnt_next = in_cnt_reg;
        out_sr_next = out_sr_reg;
        left_next = left_reg;
        skip_next = skip_reg;
        div_next = 4'h0;
        strobe_next = 1'b0;
        rd_pend_next = rd_pend_reg;
        rd_word_next = rd_word_reg;
        nap_next = nap_reg;
        if (f_start) begin
            out_sr_next = rd_pend_reg ? rd_word_reg : sample_word_i;
            left_next = dual ? asp_pkg::BITS_DUAL : asp_pkg::BITS_SINGLE;
            in_cnt_next = 6'h00;
            skip_next = cpha & ~int_sel; // msb shows on first edge
            rd_pend_next = 1'b0;
        end else if (in_frame) begin
            if (capture) begin
                in_sr_next = {in_sr_reg[30:0], s2_reg.sdi};
                if (in_cnt_reg < 6'(asp_pkg::FRAME_BITS)) begin
                    in_cnt_next = in_cnt_reg + 6'h01;
                end
            end
            if (launch && skip_reg && !int_sel) begin
                skip_next = 1'b0;
            end
            if (shift_en) begin
                // two bits leave per launch in dual mode
                out_sr_next = dual ? {out_sr_reg[29:0], 2'b00} :
                    {out_sr_reg[30:0], 1'b0};
                left_next = left_reg - 6'h01;
            end
        end
        if (f_end && in_cnt_reg >= 6'(asp_pkg::FRAME_BITS) &&
            in_sr_reg[asp_pkg::OP_MSB -: 8] == asp_pkg::OP_READ) begin
            rd_word_next = rd_word;
            rd_pend_next = 1'b1;
        end
        // return clock only in source-sync modes
        if (source_synchronous_mode && in_frame && !f_start) begin
            if (int_sel) begin
                // internal divider clocks the strobe
                div_next = tick ? 4'h0 : div_reg + 4'h1;
                strobe_next = strobe_reg;
                if (tick && (left_reg != 6'h00 || strobe_reg)) begin
                    strobe_next = ~strobe_reg;
                end
            end else begin
                strobe_next = s2_reg.sclk ^ cpol;
            end
        end
        // shared pin: second data line, alarm or general output
        if (dual) begin
            shared_next = out_sr_next[30];
        end else if (cfg == asp_pkg::CFG_ALARM) begin
            shared_next = alarm_level_i;
        end else begin
            shared_next = file_reg[asp_pkg::IDX_OUT][asp_pkg::GPO_BIT];
        end
        // nap after conversion while select stays high
        if (!file_reg[asp_pkg::IDX_PWR][asp_pkg::NAP_BIT] || in_frame) begin
            nap_next = 1'b0;
        end else if (conv_done_i) begin
            nap_next = 1'b1;
        end
        if (por_rst || app_rst) begin
            in_cnt_next = 6'h00;
            left_next = 6'h00;
            rd_pend_next = 1'b0;
            strobe_next = 1'b0;
            nap_next = 1'b0;
        end
    end

    // register all state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < asp_pkg::NREG; i++) begin
                file_reg[i] <= 32'h0000_0000;
            end
            in_sr_reg <= 32'h0000_0000;
            out_sr_reg <= 32'h0000_0000;
            rd_word_reg <= 32'h0000_0000;
            in_cnt_reg <= 6'h00;
            left_reg <= 6'h00;
            div_reg <= 4'h0;
            rd_pend_reg <= 1'b0;
            skip_reg <= 1'b0;
            strobe_reg <= 1'b0;
            shared_reg <= 1'b0;
            nap_reg <= 1'b0;
        end else begin
            file_reg <= file_next;
            in_sr_reg <= in_sr_next;
            out_sr_reg <= out_sr_next;
            rd_word_reg <= rd_word_next;
            in_cnt_reg <= in_cnt_next;
            left_reg <= left_next;
            div_reg <= div_next;
            rd_pend_reg <= rd_pend_next;
            skip_reg <= skip_next;
            strobe_reg <= strobe_next;
            shared_reg <= shared_next;
            nap_reg <= nap_next;
        end
    end

    // outputs straight from flops
    assign primary_data_out_o = out_sr_reg[31];
    assign shared_alarm_output_pin_o = shared_reg;
    assign return_strobe_pin_o = strobe_reg;
    assign nap_mode_o = nap_reg;
    assign power_down_o = file_reg[asp_pkg::IDX_PWR][asp_pkg::PD_BIT];
    assign supply_alarm_disable_o =
        file_reg[asp_pkg::IDX_PWR][asp_pkg::SUP_DIS_BIT];
    assign input_alarm_disable_o =
        file_reg[asp_pkg::IDX_PWR][asp_pkg::IN_DIS_BIT];

    // =========================================================
    // checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    dual_lanes_a: assert property (
        shift_en && dual && !f_start && !por_rst && !app_rst |=>
        out_sr_reg == {$past(out_sr_reg[29:0]), 2'b00})
        else $error("dual shift did not move two bits");
    second_line_a: assert property (
        $past(dual) |-> shared_alarm_output_pin_o == out_sr_reg[30])
        else $error("second data line not following shifter");
    launch_only_a: assert property (
        !$stable(out_sr_reg) |-> $past(shift_en || f_start))
        else $error("data moved outside a launch edge");
    spi_strobe_low_a: assert property (
        !$past(source_synchronous_mode) |-> !return_strobe_pin_o)
        else $error("strobe active outside source-sync mode");
    ext_strobe_a: assert property (
        $past(source_synchronous_mode && !int_sel && in_frame &&
        !f_start && !pin_rst) |->
        return_strobe_pin_o == $past(s2_reg.sclk ^ cpol))
        else $error("external strobe not following host clock");
    chain_reserved_a: assert property (
        (file_reg[asp_pkg::IDX_CHAIN] &
        ~asp_pkg::REG_MASK[asp_pkg::IDX_CHAIN]) == 32'h0000_0000)
        else $error("reserved identification bits not zero");
    key_byte_a: assert property (
        wr_en && wr_addr == asp_pkg::KEY_BYTE_ADDR && !pin_rst |=>
        file_reg[asp_pkg::IDX_PWR][asp_pkg::KEY_LSB +: 8] ==
        $past(wr_data))
        else $error("key byte write lost");
    key_gate_a: assert property (
        file_reg[asp_pkg::IDX_PWR][asp_pkg::KEY_LSB +: 8] !=
        asp_pkg::UNLOCK_KEY && !pin_rst |=>
        $stable(file_reg[asp_pkg::IDX_PWR][5:0]))
        else $error("control bits changed without key");
    app_keep_a: assert property (
        app_rst |=> (file_reg[asp_pkg::IDX_PWR] ==
        ($past(file_reg[asp_pkg::IDX_PWR]) & asp_pkg::POR_ONLY_MASK)))
        else $error("application reset cleared wrong bits");
    nap_exit_a: assert property (
        in_frame |=> !nap_mode_o)
        else $error("nap held during a frame");
endmodule

//--- rtl/asp_pkg.sv
// shared constants and types for the serial port and register map
package asp_pkg;
    // =========================================================
    // register map
    localparam int NREG = 9;
    localparam int IDX_CHAIN = 0;
    localparam int IDX_PWR = 1;
    localparam int IDX_IN = 2;
    localparam int IDX_OUT = 3;
    localparam logic [7:0] REG_ADDR [NREG] = '{8'h00, 8'h04, 8'h08,
        8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
    // writable bits per register, everything else reads zero
    localparam logic [31:0] REG_MASK [NREG] = '{32'h000f_0000,
        32'h0000_ff37, 32'h0000_0003, 32'h0000_1343, 32'hffff_ffff,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    // bits that only a power-on class reset clears
    localparam logic [31:0] POR_ONLY_MASK = 32'h0000_0006;
    localparam logic [7:0] KEY_BYTE_ADDR = 8'h05;
    localparam logic [7:0] UNLOCK_KEY = 8'h69;
    // =========================================================
    // field positions
    localparam int KEY_LSB = 8;
    localparam int SUP_DIS_BIT = 5;
    localparam int IN_DIS_BIT = 4;
    localparam int CLASS_BIT = 2;
    localparam int NAP_BIT = 1;
    localparam int PD_BIT = 0;
    localparam int CPOL_BIT = 1;
    localparam int CPHA_BIT = 0;
    localparam int GPO_BIT = 12;
    localparam int CFG_LSB = 8;
    localparam int RETURN_SEL_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam logic [1:0] CFG_DUAL = 2'b11;
    localparam logic [1:0] CFG_ALARM = 2'b00;
    localparam logic [1:0] MODE_SPI = 2'b00;
    // =========================================================
    // frame and timing
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] BITS_SINGLE = 6'h20;
    localparam logic [5:0] BITS_DUAL = 6'h10;
    localparam int OP_MSB = 31;
    localparam int ADDR_LSB = 16;
    localparam int CLK_PERIOD_NS = 20;
    localparam int INT_HALF_NS = 40;
    localparam int INT_HALF_CYC =
        (INT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [7:0] {
        OP_NOP = 8'h00,
        OP_WRITE = 8'h01,
        OP_READ = 8'h02
    } asp_op_t;
    // link pins after synchronisation
    typedef struct packed {
        logic reset_n;
        logic sclk;
        logic frame_n;
        logic sdi;
    } asp_link_t;
endpackage

//--- verif/asp_host_model.sv
// host controller model: frames, serial data and strobe counting
module asp_host_model (
    input wire logic core_clk_i,
    input wire logic data0_i,
    input wire logic data1_i,
    input wire logic strobe_i,
    output logic sclk_o,
    output logic select_n_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int n_rise = 0;
    logic prev = 1'b0;
    bit late_sample = 1'b0; // cpha 1: data changes and is read on sclk high
    int frame_len = 32; // fewer than 32 cuts the frame short
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // strobe rises, sampled mid-cycle where the pin has settled
    always @(negedge core_clk_i) begin
        prev <= strobe_i;
        if (strobe_i === 1'b1 && prev === 1'b0)
            n_rise <= n_rise + 1;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // store what the data lines show after launch number k
    task automatic take(inout logic [31:0] rx, input bit dual,
            input int k);
        if (!dual) begin
            rx[31 - k] = data0_i;
        end else if (k < 16) begin
            rx[31 - 2 * k] = data0_i;
            rx[30 - 2 * k] = data1_i;
        end
    endtask
    // one frame of frame_len clocks, mode 0 or mode 1 with late_sample; dual takes a bit pair per launch
    task automatic frame(input logic [31:0] tx, input bit dual,
            output logic [31:0] rx, output int rises);
        int base;
        base = n_rise;
        rx = 32'h0;
        select_n_o = 1'b0;
        wait_cyc(6);
        for (int i = 31; i >= 32 - frame_len; i--) begin
            if (!late_sample) sdi_o = tx[i];
            wait_cyc(4); // same capture point either width
            if (!late_sample) take(rx, dual, 31 - i);
            sclk_o = 1'b1;
            if (late_sample) sdi_o = tx[i];
            wait_cyc(4);
            if (late_sample) take(rx, dual, 31 - i);
            sclk_o = 1'b0;
        end
        wait_cyc(4);
        select_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line shows the inverse
        rises = n_rise - base;
        wait_cyc(10);
    endtask
endmodule

//--- verif/asp_serial_port_tb_top.sv
// self-checking bench for the serial port and register map
module asp_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst;
    logic pin_n;
    logic sclk;
    logic sel_n;
    logic sdi;
    logic [31:0] sample;
    logic done;
    logic alarm;
    logic d0;
    logic d1;
    logic strobe;
    logic nap;
    logic pd;
    logic sup;
    logic inp;
    logic [31:0] rx;
    int rises;
    int n_mismatch = 0;
    int compares = 0;
    always #10 clk = ~clk;
    asp_serial_port uut (.core_clk_i(clk), .rst_i(rst),
        .reset_pin_n_i(pin_n), .sclk_i(sclk),
        .convert_select_input_i(sel_n), .sdi_i(sdi),
        .sample_word_i(sample), .conv_done_i(done),
        .alarm_level_i(alarm), .primary_data_out_o(d0),
        .shared_alarm_output_pin_o(d1), .return_strobe_pin_o(strobe),
        .nap_mode_o(nap), .power_down_o(pd),
        .supply_alarm_disable_o(sup), .input_alarm_disable_o(inp));
    asp_host_model host (.core_clk_i(clk), .data0_i(d0), .data1_i(d1),
        .strobe_i(strobe), .sclk_o(sclk), .select_n_o(sel_n),
        .sdi_o(sdi));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.frame({asp_pkg::OP_WRITE, a, 8'h00, d}, 1'b0, rx, rises);
    endtask
    task automatic nop(input bit dual);
        host.frame({asp_pkg::OP_NOP, 24'h000000}, dual, rx, rises);
    endtask
    // read command, answer shifted out in the following frame
    task automatic rd(input logic [7:0] a, input bit dual,
            input logic [31:0] exp);
        host.frame({asp_pkg::OP_READ, a, 16'h0000}, 1'b0, rx, rises);
        nop(dual);
        check(rx, exp);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        pin_n = 1'b1;
        sample = 32'h5a5a_0ff0;
        done = 1'b0;
        alarm = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        host.wait_cyc(4);
        // reset values and sample word
        rd(8'h00, 1'b0, 32'h0);
        rd(8'h04, 1'b0, 32'h0);
        nop(1'b0);
        check(rx, sample);
        $display("test reset done");
        // chain address and reserved bits
        wr(8'h02, 8'hff);
        wr(8'h00, 8'hff);
        wr(8'h03, 8'hff);
        rd(8'h00, 1'b0, 32'h000f_0000);
        $display("test chain address done");
        // byte lanes and base addresses
        for (int i = 0; i < 4; i++) wr(8'(8'h10 + i), 8'(8'h11 * (i + 1)));
        rd(8'h10, 1'b0, 32'h4433_2211);
        rd(8'h13, 1'b0, 32'h4433_2211);
        for (int i = 5; i < asp_pkg::NREG; i++)
            wr(asp_pkg::REG_ADDR[i], 8'(8'ha0 + i));
        for (int i = 5; i < asp_pkg::NREG; i++)
            rd(asp_pkg::REG_ADDR[i], 1'b0, 32'(8'ha0 + i));
        rd(8'h18, 1'b0, 32'h0);
        rd(8'h2c, 1'b0, 32'h0);
        $display("test map done");
        // key protection of the reset-power register
        wr(8'h04, 8'h3f);
        rd(8'h04, 1'b0, 32'h0);
        wr(8'h05, 8'h69);
        wr(8'h04, 8'h3f);
        rd(8'h04, 1'b0, 32'h0000_6937);
        check({29'h0, pd, sup, inp}, 32'h7);
        host.wait_cyc(1);
        done = 1'b1;
        host.wait_cyc(1);
        done = 1'b0;
        host.wait_cyc(3);
        check({31'h0, nap}, 32'h1);
        nop(1'b0);
        check({31'h0, nap}, 32'h0);
        alarm = 1'b1;
        host.wait_cyc(3);
        check({31'h0, d1}, 32'h1);
        alarm = 1'b0;
        $display("test power control done");
        // dual output and return strobe
        wr(8'h0d, 8'h03);
        rd(8'h10, 1'b1, 32'h4433_2211);
        wr(8'h0c, 8'h41);
        nop(1'b1);
        check(32'(rises), 32'h10);
        wr(8'h0d, 8'h11);
        check({31'h0, d1}, 32'h1);
        nop(1'b0);
        check(32'(rises), 32'h20);
        wr(8'h0c, 8'h01);
        nop(1'b0);
        check(32'(rises), 32'h20);
        wr(8'h0c, 8'h00);
        nop(1'b0);
        check(32'(rises), 32'h0);
        $display("test output modes done");
        // late-capture phase, new sample word and a cut frame
        wr(8'h08, 8'h01);
        host.late_sample = 1'b1;
        rd(8'h10, 1'b0, 32'h4433_2211);
        sample = 32'hc3a5_0f96;
        nop(1'b0);
        check(rx, sample);
        host.frame_len = 24;
        wr(8'h14, 8'h5c);
        host.frame_len = 32;
        rd(8'h14, 1'b0, 32'h0000_00a5);
        wr(8'h08, 8'h00);
        host.late_sample = 1'b0;
        $display("test capture phase done");
        // application reset then power-on reset
        pin_n = 1'b0;
        host.wait_cyc(6);
        pin_n = 1'b1;
        host.wait_cyc(6);
        rd(8'h04, 1'b0, 32'h0000_0006);
        rd(8'h00, 1'b0, 32'h0);
        check({29'h0, pd, sup, inp}, 32'h0);
        rst = 1'b1;
        host.wait_cyc(2);
        rst = 1'b0;
        host.wait_cyc(4);
        rd(8'h04, 1'b0, 32'h0);
        wr(8'h02, 8'h05);
        rd(8'h00, 1'b0, 32'h0005_0000);
        pin_n = 1'b0;
        host.wait_cyc(6);
        pin_n = 1'b1;
        host.wait_cyc(6);
        rd(8'h00, 1'b0, 32'h0);
        $display("test reset classes done");
        conclude();
    end
endmodule
